// ===== hdl/lprws_top.sv
// Low-power mode, wake and reset sequencer.
// Assumes core requests (idle, interrupts) arrive on the system clock; pins are asynchronous.
// Operation
// (R01) A watchdog reset drives the reset pin low as an output for at least 128 input-clock periods.
// (R02) Reset-vector execution starts 36 output-clock half-periods after the PLL locks.
// (R03) Execution is held off until the 4096 input-clock PLL lock interval has elapsed.
// (R04) Execution resumes 12 cycles after clock restart from light idle and 15 from clock-stopped idle.
// (R05) In clock-stopped idle the output clock stops high 4 cycles after the idle instruction.
// (R06) In halt the oscillator powers off 4 cycles after the idle instruction.
// (R07) Halt wake restarts the oscillator and treats the clock as running only after start-up time.
// (R08) Either idle mode is left on any valid enabled interrupt or on reset.
// (R09) The outside source holds the protection input low 6 cycles, or 12 with the long qualifier.
// (R10) A qualified protection low tri-states all PWM outputs after qualifier plus sync cycles.
// (R11) An external interrupt edge leads to a vector fetch 10 cycles later.
// (R12) Halt wake restores the multiplication ratio held on halt entry.
// (R13) Halt wake by the protection input fetches its vector only when its interrupt is enabled.
// (R14) With that interrupt disabled the device still wakes and continues without a vector.
`timescale 1ns/10ps
module lprws_top #(
    parameter int unsigned PLL_LOCK_REF = lprws_pkg::PLL_LOCK_REF,
    parameter int unsigned OSC_START    = lprws_pkg::OSC_START_CYC
) (
    // Clock and reset
    input  wire logic                              i_clk,
    input  wire logic                              i_reset_n,
    // Reset pin, three signals
    input  wire logic                              i_reset_pin,
    output logic                                   o_reset_pin,
    output logic                                   o_reset_pin_oe,
    // Core requests
    input  wire logic                              i_watchdog_reset,
    input  wire logic                              i_idle_req,
    input  wire logic [1:0]                        i_idle_mode,
    input  wire logic                              i_wake_irq,
    input  wire logic                              i_ext_irq,
    input  wire logic [lprws_pkg::RATIO_W-1:0]     i_pll_ratio,
    // Protection input and qualifier selection
    input  wire logic                              i_power_drive_protect_input_n,
    input  wire logic                              i_qual_long,
    input  wire logic                              i_protect_irq_en,
    // Status and control outputs
    output logic                                   o_core_clk_en,
    output logic                                   o_core_output_clock_hold,
    output logic                                   o_osc_on,
    output logic                                   o_run,
    output logic                                   o_reset_vector,
    output logic                                   o_irq_vector,
    output logic                                   o_protect_vector,
    output logic                                   o_pwm_hiz,
    output logic [lprws_pkg::RATIO_W-1:0]          o_pll_ratio
);
    typedef enum logic [3:0] {
        S_PIN_RESET, S_LOCK, S_VEC_WAIT, S_RUN, S_ENTER, S_IDLE, S_OSC_START, S_RELOCK, S_RESUME
    } lprws_state_t;

    localparam logic [lprws_pkg::CNT_W-1:0] WDOG_CYC =
        lprws_pkg::CNT_W'(lprws_pkg::WDOG_RST_REF * lprws_pkg::REF_DIV);
    localparam logic [lprws_pkg::CNT_W-1:0] LOCK_CYC  = lprws_pkg::CNT_W'(PLL_LOCK_REF * lprws_pkg::REF_DIV);
    localparam logic [lprws_pkg::CNT_W-1:0] VEC_CYC   = lprws_pkg::CNT_W'(lprws_pkg::VEC_DELAY_CYC);
    localparam logic [lprws_pkg::CNT_W-1:0] OSC_CYC   = lprws_pkg::CNT_W'(OSC_START);
    localparam logic [lprws_pkg::CNT_W-1:0] ENTER_CYC = lprws_pkg::CNT_W'(lprws_pkg::IDLE_STOP_CYC);
    localparam logic [lprws_pkg::CNT_W-1:0] LIGHT_CYC = lprws_pkg::CNT_W'(lprws_pkg::WAKE_LIGHT_CYC);
    localparam logic [lprws_pkg::CNT_W-1:0] STOP_CYC  = lprws_pkg::CNT_W'(lprws_pkg::WAKE_STOP_CYC);
    localparam logic [lprws_pkg::CNT_W-1:0] IRQ_CYC   = lprws_pkg::CNT_W'(lprws_pkg::INT_VEC_CYC);

    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pin synchronisers; first stages feed only second stages
    logic [1:0] pin_sync_q;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync_q <= 2'h0;
        end else begin
            pin_sync_q <= {pin_sync_q[0], i_reset_pin};
        end
    end

    lprws_qual_if qif ();
    assign qif.raw_n    = i_power_drive_protect_input_n;
    assign qif.long_sel = i_qual_long;
    lprws_qual u_qual (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .q       (qif.seq)
    );

    lprws_state_t                          st_q, st_d;
    lprws_pkg::lprws_mode_t                mode_q, mode_d;
    logic [lprws_pkg::CNT_W-1:0]           cnt_q, cnt_d;
    logic [lprws_pkg::CNT_W-1:0]           icnt_q, icnt_d;
    logic                                  ipend_q, ipend_d;
    logic                                  drive_q, drive_d;
    logic                                  clk_en_q, clk_en_d;
    logic                                  hold_q, hold_d;
    logic                                  osc_q, osc_d;
    logic                                  run_q, run_d;
    logic                                  rvec_q, rvec_d;
    logic                                  ivec_q, ivec_d;
    logic                                  pvec_q, pvec_d;
    logic                                  hiz_q, hiz_d;
    logic                                  pwake_q, pwake_d;
    logic [lprws_pkg::RATIO_W-1:0]         ratio_q, ratio_d;
    logic                                  wake;

    always_comb begin
        st_d     = st_q;
        mode_d   = mode_q;
        cnt_d    = cnt_q;
        icnt_d   = icnt_q;
        ipend_d  = ipend_q;
        drive_d  = drive_q;
        clk_en_d = clk_en_q;
        hold_d   = hold_q;
        osc_d    = osc_q;
        run_d    = run_q;
        rvec_d   = 1'b0;
        ivec_d   = 1'b0;
        pvec_d   = 1'b0;
        pwake_d  = pwake_q;
        ratio_d  = ratio_q;
        // The qualified fault holds while the synchronised pin stays low
        hiz_d    = qif.fault; // [R10]
        wake     = i_wake_irq | qif.fault; // [R08]
        if (run_q && i_ext_irq && !ipend_q) begin
            ipend_d = 1'b1;
            icnt_d  = IRQ_CYC - 1'b1;
        end else if (ipend_q) begin
            if (icnt_q == '0) begin
                ipend_d = 1'b0;
                ivec_d  = 1'b1; // [R11]
            end else begin
                icnt_d = icnt_q - 1'b1;
            end
        end
        case (st_q)
            S_PIN_RESET: begin
                run_d = 1'b0;
                if (drive_q) begin
                    if (cnt_q == '0) begin
                        drive_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end else if (pin_sync_q[1]) begin
                    st_d  = S_LOCK;
                    cnt_d = LOCK_CYC - 1'b1;
                end
            end
            S_LOCK: begin
                if (cnt_q == '0) begin // [R03]
                    st_d     = S_VEC_WAIT;
                    clk_en_d = 1'b1;
                    cnt_d    = VEC_CYC - 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            S_VEC_WAIT: begin
                if (cnt_q == '0) begin
                    st_d   = S_RUN;
                    run_d  = 1'b1;
                    rvec_d = 1'b1; // [R02]
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            S_RUN: begin
                if (i_idle_req && i_idle_mode != 2'(lprws_pkg::LPRWS_MODE_NONE)) begin
                    mode_d  = lprws_pkg::lprws_mode_t'(i_idle_mode);
                    ratio_d = i_pll_ratio; // [R12]
                    run_d   = 1'b0;
                    st_d    = S_ENTER;
                    cnt_d   = ENTER_CYC - 1'b1;
                end
            end
            S_ENTER: begin
                if (cnt_q == '0) begin
                    st_d = S_IDLE;
                    if (mode_q != lprws_pkg::LPRWS_MODE_LIGHT) begin
                        clk_en_d = 1'b0;
                        hold_d   = 1'b1; // [R05]
                    end
                    if (mode_q == lprws_pkg::LPRWS_MODE_HALT) begin
                        osc_d = 1'b0; // [R06]
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            S_IDLE: begin
                if (wake) begin
                    pwake_d = qif.fault;
                    if (mode_q == lprws_pkg::LPRWS_MODE_HALT) begin
                        osc_d = 1'b1; // [R07]
                        st_d  = S_OSC_START;
                        cnt_d = OSC_CYC - 1'b1;
                    end else begin
                        clk_en_d = 1'b1;
                        hold_d   = 1'b0;
                        st_d     = S_RESUME;
                        cnt_d = (mode_q == lprws_pkg::LPRWS_MODE_LIGHT) ? LIGHT_CYC - 1'b1 : STOP_CYC - 1'b1; // [R04]
                    end
                end
            end
            S_OSC_START: begin
                if (cnt_q == '0) begin // [R07]
                    st_d  = S_RELOCK;
                    cnt_d = LOCK_CYC - 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            S_RELOCK: begin
                if (cnt_q == '0) begin // [R03]
                    clk_en_d = 1'b1;
                    hold_d   = 1'b0;
                    st_d     = S_RESUME;
                    cnt_d    = '0;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            S_RESUME: begin
                if (cnt_q == '0) begin
                    st_d   = S_RUN;
                    run_d  = 1'b1;
                    // Vector only if enabled; otherwise continue after the idle instruction [R13] [R14]
                    pvec_d = pwake_q & i_protect_irq_en;
                    pwake_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                st_d = S_PIN_RESET;
            end
        endcase
        // Watchdog outranks every state except S_PIN_RESET and owns the pin for its full pulse
        if (i_watchdog_reset && st_q != S_PIN_RESET) begin
            st_d     = S_PIN_RESET;
            drive_d  = 1'b1; // [R01]
            cnt_d    = WDOG_CYC - 1'b1;
            run_d    = 1'b0;
            clk_en_d = 1'b0;
            hold_d   = 1'b0;
            osc_d    = 1'b1;
            ipend_d  = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q     <= S_PIN_RESET;
            mode_q   <= lprws_pkg::LPRWS_MODE_NONE;
            cnt_q    <= '0;
            icnt_q   <= '0;
            ipend_q  <= 1'b0;
            drive_q  <= 1'b0;
            clk_en_q <= 1'b0;
            hold_q   <= 1'b0;
            osc_q    <= 1'b1;
            run_q    <= 1'b0;
            rvec_q   <= 1'b0;
            ivec_q   <= 1'b0;
            pvec_q   <= 1'b0;
            hiz_q    <= 1'b0;
            pwake_q  <= 1'b0;
            ratio_q  <= '0;
        end else begin
            st_q     <= st_d;
            mode_q   <= mode_d;
            cnt_q    <= cnt_d;
            icnt_q   <= icnt_d;
            ipend_q  <= ipend_d;
            drive_q  <= drive_d;
            clk_en_q <= clk_en_d;
            hold_q   <= hold_d;
            osc_q    <= osc_d;
            run_q    <= run_d;
            rvec_q   <= rvec_d;
            ivec_q   <= ivec_d;
            pvec_q   <= pvec_d;
            hiz_q    <= hiz_d;
            pwake_q  <= pwake_d;
            ratio_q  <= ratio_d;
        end
    end

    assign o_reset_pin              = 1'b0;
    assign o_reset_pin_oe           = drive_q;
    assign o_core_clk_en            = clk_en_q;
    assign o_core_output_clock_hold = hold_q;
    assign o_osc_on                 = osc_q;
    assign o_run                    = run_q;
    assign o_reset_vector           = rvec_q;
    assign o_irq_vector             = ivec_q;
    assign o_protect_vector         = pvec_q;
    assign o_pwm_hiz                = hiz_q;
    assign o_pll_ratio              = ratio_q;
endmodule

// ===== hdl/lprws_pkg.sv
// Constants for the low-power reset and wake sequencer.
// Assumes a single 25 MHz system clock; input-clock periods are counted by an enable.
package lprws_pkg;
    localparam int unsigned CLK_PERIOD_NS     = 40;
    // Input reference clock period, expressed in system clock cycles (one enable per period)
    localparam int unsigned REF_DIV           = 1;
    localparam int unsigned WDOG_RST_REF      = 128;
    localparam int unsigned PLL_LOCK_REF      = 4096;
    localparam int unsigned VEC_HALF_PERIODS  = 36;
    localparam int unsigned VEC_DELAY_CYC     = (VEC_HALF_PERIODS + 1) / 2;
    localparam int unsigned WAKE_LIGHT_CYC    = 12;
    localparam int unsigned WAKE_STOP_CYC     = 15;
    localparam int unsigned IDLE_STOP_CYC     = 4;
    localparam int unsigned IDLE_OSC_OFF_CYC  = 4;
    localparam int unsigned QUAL_SHORT_CYC    = 6;
    localparam int unsigned QUAL_LONG_CYC     = 12;
    localparam int unsigned INT_VEC_CYC       = 10;
    localparam int unsigned OSC_START_CYC     = 1000;
    localparam int unsigned CNT_W             = 16;
    localparam int unsigned SYNC_STAGES       = 2;
    localparam int unsigned PWM_CH            = 8;
    localparam int unsigned RATIO_W           = 3;
    typedef enum logic [1:0] {
        LPRWS_MODE_LIGHT,
        LPRWS_MODE_STOP,
        LPRWS_MODE_HALT,
        LPRWS_MODE_NONE
    } lprws_mode_t;
endpackage

// ===== hdl/lprws_qual_if.sv
// Carrier between the sequencer and its protection-input qualifier.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface lprws_qual_if;
    logic raw_n;
    logic long_sel;
    logic fault;
    modport seq  (output raw_n, output long_sel, input fault);
    modport qual (input raw_n, input long_sel, output fault);
endinterface

// ===== hdl/lprws_qual.sv
// Synchronises and qualifies the power-drive-protection input.
// Assumes raw_n is asynchronous to the system clock.
`timescale 1ns/10ps
module lprws_qual (
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    // Qualifier link
    lprws_qual_if.qual q
);
    logic [1:0]                      sync_q, sync_d;
    logic [lprws_pkg::CNT_W-1:0]     cnt_q, cnt_d;
    logic                            fault_q, fault_d;
    logic [lprws_pkg::CNT_W-1:0]     need;

    always_comb begin
        need    = q.long_sel ? lprws_pkg::CNT_W'(lprws_pkg::QUAL_LONG_CYC)
                             : lprws_pkg::CNT_W'(lprws_pkg::QUAL_SHORT_CYC);
        sync_d  = {sync_q[0], q.raw_n};
        cnt_d   = cnt_q;
        fault_d = 1'b0;
        if (sync_q[1]) begin
            cnt_d = '0;
        end else if (cnt_q < need) begin
            cnt_d = cnt_q + 1'b1;
        end
        // Low held for the full qualifier window; extra register is the sync cycle [R10]
        if (!sync_q[1] && cnt_d >= need) begin
            fault_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_q  <= 2'h3;
            cnt_q   <= '0;
            fault_q <= 1'b0;
        end else begin
            sync_q  <= sync_d;
            cnt_q   <= cnt_d;
            fault_q <= fault_d;
        end
    end

    assign q.fault = fault_q;
endmodule

// ===== test/lprws_src_model.sv
// Model of the outside sources: open-drain reset wire and protection input.
// Assumes the bench calls fault_pulse from its own process.
`timescale 1ns/10ps
module lprws_src_model (
    // Clock and device side of the reset wire
    input  wire logic i_clk,
    input  wire logic i_pin_oe,
    input  wire logic i_pin_out,
    // Levels seen by the device
    output logic      o_pin,
    output logic      o_protect_n
);
    // Pull-up holds the wire high whenever nobody pulls it down
    assign o_pin = (i_pin_oe && !i_pin_out) ? 1'b0 : 1'b1;
    initial o_protect_n = 1'b1;
    // Lengths below the qualifier span are used only where a refusal is wanted
    task automatic fault_pulse(input int n);
        @(posedge i_clk);
        o_protect_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_protect_n <= 1'b1;
    endtask
endmodule

// ===== test/lprws_properties.sv
// Port-level checks for the reset and wake sequencer.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/10ps
module lprws_props_chk #(
    parameter int unsigned PLL_LOCK_REF = lprws_pkg::PLL_LOCK_REF
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Watched inputs
    input wire logic i_reset_pin,
    input wire logic i_idle_req,
    input wire logic [1:0] i_idle_mode,
    input wire logic i_ext_irq,
    input wire logic [lprws_pkg::RATIO_W-1:0] i_pll_ratio,
    input wire logic i_power_drive_protect_input_n,
    input wire logic i_qual_long,
    input wire logic i_protect_irq_en,
    // Watched outputs
    input wire logic o_reset_pin,
    input wire logic o_reset_pin_oe,
    input wire logic o_core_clk_en,
    input wire logic o_core_output_clock_hold,
    input wire logic o_osc_on,
    input wire logic o_run,
    input wire logic o_reset_vector,
    input wire logic o_irq_vector,
    input wire logic o_protect_vector,
    input wire logic o_pwm_hiz,
    input wire logic [lprws_pkg::RATIO_W-1:0] o_pll_ratio
);
    logic [15:0] oe_cnt_q, oe_cnt_d, hi_cnt_q, hi_cnt_d;
    logic [7:0] lo_cnt_q, lo_cnt_d;
    logic [lprws_pkg::RATIO_W-1:0] ratio_q, ratio_d;
    logic take;
    assign take = o_run && i_idle_req && (i_idle_mode != 2'h3);
    // Counters saturate so a long quiet spell never wraps into a false match
    always_comb begin
        oe_cnt_d = o_reset_pin_oe ? oe_cnt_q + {15'h0, oe_cnt_q != 16'hFFFF} : 16'h0;
        hi_cnt_d = i_reset_pin ? hi_cnt_q + {15'h0, hi_cnt_q != 16'hFFFF} : 16'h0;
        lo_cnt_d = !i_power_drive_protect_input_n ? lo_cnt_q + {7'h0, lo_cnt_q != 8'hFF} : 8'h0;
        ratio_d = take ? i_pll_ratio : ratio_q;
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            oe_cnt_q <= 16'h0;
            hi_cnt_q <= 16'h0;
            lo_cnt_q <= 8'h0;
            ratio_q <= '0;
        end else begin
            oe_cnt_q <= oe_cnt_d;
            hi_cnt_q <= hi_cnt_d;
            lo_cnt_q <= lo_cnt_d;
            ratio_q <= ratio_d;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    a_wdog_pulse_len: assert property ($fell(o_reset_pin_oe) |-> oe_cnt_q >= 16'h0080)
        else $error("reset pin drive too short");
    a_pin_drive_low: assert property (o_reset_pin_oe |-> !o_reset_pin)
        else $error("reset pin driven high");
    a_vec_after_lock: assert property (o_reset_vector |-> hi_cnt_q >= PLL_LOCK_REF + 18)
        else $error("reset vector before lock delay");
    a_idle_stops_run: assert property (take |=> !o_run)
        else $error("run kept after idle");
    a_clock_stop_high: assert property (take && i_idle_mode == 2'h1 |-> ##[4:6]
        (o_core_output_clock_hold && !o_core_clk_en)) else $error("clock not stopped high");
    a_osc_off_halt: assert property (take && i_idle_mode == 2'h2 |-> ##[4:6] !o_osc_on)
        else $error("oscillator not off");
    a_hiz_qualified: assert property ($rose(o_pwm_hiz) |-> $past(lo_cnt_q, 3) >= (i_qual_long ? 8'h0C : 8'h06))
        else $error("hiz before qualified low");
    a_hiz_short_due: assert property (lo_cnt_q == 8'h06 && !i_qual_long |-> ##3 o_pwm_hiz)
        else $error("hiz late short qualifier");
    a_hiz_long_due: assert property (lo_cnt_q == 8'h0C && i_qual_long |-> ##3 o_pwm_hiz)
        else $error("hiz late long qualifier");
    a_irq_vec_delay: assert property ($rose(i_ext_irq) && o_run |-> ##[10:12] o_irq_vector)
        else $error("irq vector not in time");
    a_prot_vec_enabled: assert property (o_protect_vector |-> i_protect_irq_en)
        else $error("protect vector while disabled");
    a_ratio_restore: assert property ($rose(o_run) |-> o_pll_ratio == ratio_q)
        else $error("ratio not restored");
endmodule
bind lprws_top lprws_props_chk #(.PLL_LOCK_REF(PLL_LOCK_REF)) chk_u (.i_clk, .i_reset_n, .i_reset_pin,
    .i_idle_req, .i_idle_mode, .i_ext_irq, .i_pll_ratio, .i_power_drive_protect_input_n, .i_qual_long,
    .i_protect_irq_en, .o_reset_pin, .o_reset_pin_oe, .o_core_clk_en, .o_core_output_clock_hold, .o_osc_on,
    .o_run, .o_reset_vector, .o_irq_vector, .o_protect_vector, .o_pwm_hiz, .o_pll_ratio);

// ===== test/testbench.sv
// Self-checking bench for the reset and wake sequencer.
// Assumes shortened lock and start-up counts and one 25 MHz clock.
`timescale 1ns/10ps
module testbench;
    localparam int LOCK = 16;
    localparam int OSC = 8;
    typedef struct {
        logic [1:0] mode;
        logic [2:0] ratio;
        logic osc, clk, run;
        int lo, hi;
    } lprws_row_t;
    lprws_row_t rows [4] = '{'{2'h0, 3'h1, 1'b1, 1'b1, 1'b0, 12, 16}, '{2'h1, 3'h2, 1'b1, 1'b0, 1'b0, 15, 19},
        '{2'h2, 3'h5, 1'b0, 1'b0, 1'b0, OSC + LOCK, OSC + LOCK + 8}, '{2'h3, 3'h6, 1'b1, 1'b1, 1'b1, 0, 0}};
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_watchdog_reset = 1'b0, i_idle_req = 1'b0, i_wake_irq = 1'b0;
    logic i_ext_irq = 1'b0, i_qual_long = 1'b0, i_protect_irq_en = 1'b0, prot_seen = 1'b0;
    logic [1:0] i_idle_mode = 2'h0;
    logic [lprws_pkg::RATIO_W-1:0] i_pll_ratio = 3'h0, o_pll_ratio;
    logic i_reset_pin, i_power_drive_protect_input_n, o_reset_pin, o_reset_pin_oe, o_core_clk_en, o_osc_on;
    logic o_core_output_clock_hold, o_run, o_reset_vector, o_irq_vector, o_protect_vector, o_pwm_hiz;
    int failures = 0, check_count = 0;
    always #20 i_clk = ~i_clk;
    lprws_top #(.PLL_LOCK_REF(LOCK), .OSC_START(OSC)) dut_u (.i_clk, .i_reset_n, .i_reset_pin, .o_reset_pin,
        .o_reset_pin_oe, .i_watchdog_reset, .i_idle_req, .i_idle_mode, .i_wake_irq, .i_ext_irq, .i_pll_ratio,
        .i_power_drive_protect_input_n, .i_qual_long, .i_protect_irq_en, .o_core_clk_en,
        .o_core_output_clock_hold, .o_osc_on, .o_run, .o_reset_vector, .o_irq_vector, .o_protect_vector,
        .o_pwm_hiz, .o_pll_ratio);
    lprws_src_model src_u (.i_clk, .i_pin_oe(o_reset_pin_oe), .i_pin_out(o_reset_pin), .o_pin(i_reset_pin),
        .o_protect_n(i_power_drive_protect_input_n));
    // The vector is a one-cycle pulse, so it is latched rather than sampled once
    always @(posedge i_clk) prot_seen <= i_reset_n && (prot_seen || o_protect_vector === 1'b1);
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic check_rng(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            failures++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return o_run;
            1: return o_reset_vector;
            2: return o_irq_vector;
            3: return o_pwm_hiz;
            4: return o_reset_pin_oe;
            default: return !o_reset_pin_oe;
        endcase
    endfunction
    // Counts edges until the chosen output is seen high, bounded by lim
    task automatic wait_sig(input int s, input int lim, output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (pick(s) !== 1'b1 && n < lim);
    endtask
    task automatic boot(output int n);
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (20) @(posedge i_clk);
        check("osc_on in reset", 1'b1, o_osc_on);
        check("run in reset", 1'b0, o_run);
        i_reset_n <= 1'b1;
        wait_sig(1, 200, n);
    endtask
    task automatic enter_idle(input logic [1:0] mode, input logic [2:0] ratio);
        @(posedge i_clk);
        i_idle_mode <= mode;
        i_pll_ratio <= ratio;
        i_idle_req <= 1'b1;
        @(posedge i_clk);
        i_idle_req <= 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_clk);
        failures++;
        $display("ERROR watchdog expected finish seen timeout");
        give_verdict();
    end
    initial begin : main
        int n;
        boot(n);
        check_rng("reset vector delay", LOCK + 18, LOCK + 28, n);
        check("run after vector", 1'b1, o_run);
        $display("test reset done");
        foreach (rows[k]) begin
            enter_idle(rows[k].mode, rows[k].ratio);
            check("osc_on", rows[k].osc, o_osc_on);
            check("clk_en", rows[k].clk, o_core_clk_en);
            check("run", rows[k].run, o_run);
            if (rows[k].mode != 2'h2) begin
                check("clock hold", rows[k].mode == 2'h1, o_core_output_clock_hold);
            end
            if (!rows[k].run) begin
                @(posedge i_clk);
                i_pll_ratio <= ~rows[k].ratio;
                i_wake_irq <= 1'b1;
                wait_sig(0, 100, n);
                check_rng("wake delay", rows[k].lo, rows[k].hi, n);
                check("ratio", rows[k].ratio, o_pll_ratio);
                @(posedge i_clk);
                i_wake_irq <= 1'b0;
            end
            $display("test idle mode %0d done", rows[k].mode);
        end
        @(posedge i_clk);
        i_ext_irq <= 1'b1;
        wait_sig(2, 40, n);
        check_rng("irq vector delay", 10, 13, n);
        @(posedge i_clk);
        i_ext_irq <= 1'b0;
        $display("test ext irq done");
        for (int q = 0; q < 2; q++) begin
            boot(n);
            @(posedge i_clk);
            i_qual_long <= q[0];
            src_u.fault_pulse(q ? 10 : 4);
            repeat (8) @(posedge i_clk);
            check("hiz after short low", 1'b0, o_pwm_hiz);
            fork
                src_u.fault_pulse(q ? 12 : 6);
                wait_sig(3, 30, n);
            join
            check_rng("hiz delay", q ? 14 : 8, q ? 17 : 11, n);
            $display("test fault qualifier %0d done", q);
        end
        for (int en = 0; en < 2; en++) begin
            boot(n);
            @(posedge i_clk);
            i_qual_long <= 1'b0;
            i_protect_irq_en <= en[0];
            enter_idle(2'h2, 3'h3);
            fork
                src_u.fault_pulse(10);
                wait_sig(0, 100, n);
            join
            repeat (4) @(posedge i_clk);
            check("run after fault wake", 1'b1, o_run);
            check("protect vector", en[0], prot_seen);
            $display("test halt fault wake %0d done", en);
        end
        @(posedge i_clk);
        i_watchdog_reset <= 1'b1;
        @(posedge i_clk);
        i_watchdog_reset <= 1'b0;
        wait_sig(4, 10, n);
        check("reset wire low", 1'b0, i_reset_pin);
        wait_sig(5, 300, n);
        check_rng("reset drive length", 128, 132, n + 1);
        wait_sig(1, 200, n);
        check_rng("relock vector delay", LOCK + 18, LOCK + 28, n);
        $display("test watchdog done");
        give_verdict();
    end
endmodule
